/* rtl/ccf_config_regs.sv */
// Controller configuration register bank with APB slave
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module ccf_config_regs #(
    parameter logic [3:0] MIN_PAGE = 4'h0,   // Smallest supported page code
    parameter logic [3:0] MAX_PAGE = 4'h0,   // Largest supported page code
    parameter logic [7:0] ARB_SUPPORT = 8'h03, // Supported arbitration codes, one bit each
    parameter logic [7:0] CMDSET_SUPPORT = 8'h01 // Supported command set codes
) (
    input wire logic clk_in,                  // 100 MHz clock
    input wire logic rst_n_in,                // Async reset, active low
    input wire logic psel_in,                 // APB select
    input wire logic penable_in,              // APB enable
    input wire logic pwrite_in,               // APB write
    input wire logic [11:0] paddr_in,         // APB byte address
    input wire logic [31:0] pwdata_in,        // APB write data
    output logic [31:0] prdata_out,           // APB read data
    output logic pready_out,                  // APB ready
    output logic pslverr_out,                 // APB error
    output logic run_out,                     // Command processing enabled
    output logic ctrl_reset_out,              // Controller reset pulse
    output logic [2:0] arb_mode_out,          // One-hot arbitration mode
    output logic [4:0] page_shift_out,        // Log2 of page list entry size
    output logic [2:0] command_set_out,       // Command set for all I/O queues
    output logic config_error_out             // Programmed value unsupported
);
    logic run_q;
    logic [2:0] arb_q;
    logic [3:0] page_q;
    logic [2:0] cmdset_q;
    logic [2:0] rst_cnt_q;
    logic ctrl_reset_q;
    logic [2:0] arb_mode_q;
    logic [4:0] page_shift_q;
    logic [2:0] cmdset_out_q;
    logic cfg_err_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic pready_q;

    function automatic logic code_supported(input logic [7:0] mask, input logic [2:0] code);
        code_supported = mask[code];
    endfunction : code_supported

    wire access = psel_in && penable_in;
    wire hit_cfg = paddr_in == ccf_pkg::CONFIG_ADDR;
    wire hit_caps = paddr_in == ccf_pkg::CAPS_ADDR;
    wire hit_stat = paddr_in == ccf_pkg::STATUS_ADDR;
    wire hit_der = paddr_in == ccf_pkg::DERIVED_ADDR;
    wire mapped = hit_cfg || hit_caps || hit_stat || hit_der;
    wire cfg_wr = access && pwrite_in && hit_cfg;
    wire new_run = pwdata_in[ccf_pkg::RUN_POS];
    // Fields are frozen while running; a write that also clears run is accepted as a disable
    wire fields_open = !run_q;
    wire run_fall = cfg_wr && run_q && !new_run;
    wire [2:0] wr_arb = pwdata_in[ccf_pkg::ARB_HI:ccf_pkg::ARB_LO];
    wire [3:0] wr_page = pwdata_in[ccf_pkg::PAGE_HI:ccf_pkg::PAGE_LO];
    wire [2:0] wr_cmdset = pwdata_in[ccf_pkg::CMDSET_HI:ccf_pkg::CMDSET_LO];
    // Reserved bits 3:1 are never stored and read zero
    wire [31:0] cfg_view = {18'h0, arb_q, page_q, cmdset_q, 3'h0, run_q};
    wire [31:0] caps_view = {8'h0, CMDSET_SUPPORT, ARB_SUPPORT, MAX_PAGE, MIN_PAGE};
    wire [31:0] stat_view = {30'h0, cfg_err_q, run_q && !ctrl_reset_q};
    wire [31:0] der_view = {24'h0, arb_mode_q, page_shift_q};
    wire [31:0] rd_mux = hit_cfg ? cfg_view : hit_caps ? caps_view :
        hit_stat ? stat_view : hit_der ? der_view : 32'h0;

    wire [2:0] arb_mode_d = (arb_q == ccf_pkg::ARB_ROUND_ROBIN) ? 3'(ccf_pkg::MODE_ROUND_ROBIN) :
        (arb_q == ccf_pkg::ARB_WEIGHTED_URGENT) ? 3'(ccf_pkg::MODE_WEIGHTED) :
        3'(ccf_pkg::MODE_OTHER);
    wire arb_bad = !code_supported(ARB_SUPPORT, arb_q) ||
        (arb_q != ccf_pkg::ARB_ROUND_ROBIN && arb_q != ccf_pkg::ARB_WEIGHTED_URGENT &&
         arb_q != ccf_pkg::ARB_VENDOR);
    wire page_bad = page_q < MIN_PAGE || page_q > MAX_PAGE;
    wire cmd_bad = cmdset_q != ccf_pkg::CMDSET_STORAGE ||
        !code_supported(CMDSET_SUPPORT, cmdset_q);
    wire [4:0] page_shift_d = ccf_pkg::PAGE_SHIFT_BASE + {1'b0, page_q};

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_q <= 1'b0;
            arb_q <= ccf_pkg::ARB_RESET;
            page_q <= ccf_pkg::PAGE_RESET;
            cmdset_q <= ccf_pkg::CMDSET_RESET;
        end else if (run_fall) begin
            run_q <= 1'b0;
            arb_q <= ccf_pkg::ARB_RESET;
            page_q <= ccf_pkg::PAGE_RESET;
            cmdset_q <= ccf_pkg::CMDSET_RESET;
        end else if (cfg_wr) begin
            run_q <= new_run;
            if (fields_open) begin
                arb_q <= wr_arb;
                page_q <= wr_page;
                cmdset_q <= wr_cmdset;
            end
        end
    end

    // Controller reset held for a few cycles so downstream engines can flush queues
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_cnt_q <= 3'h0;
            ctrl_reset_q <= 1'b0;
        end else if (run_fall) begin
            rst_cnt_q <= 3'(ccf_pkg::RESET_CYCLES - 1);
            ctrl_reset_q <= 1'b1;
        end else if (rst_cnt_q != 3'h0) begin
            rst_cnt_q <= rst_cnt_q - 3'h1;
        end else begin
            ctrl_reset_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arb_mode_q <= 3'(ccf_pkg::MODE_ROUND_ROBIN);
            page_shift_q <= ccf_pkg::PAGE_SHIFT_BASE;
            cmdset_out_q <= ccf_pkg::CMDSET_RESET;
            cfg_err_q <= 1'b0;
        end else begin
            arb_mode_q <= arb_mode_d;
            page_shift_q <= page_shift_d;
            cmdset_out_q <= cmdset_q;
            // Flag only, checked against host obligations for debug visibility
            cfg_err_q <= arb_bad || page_bad || cmd_bad;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
            pready_q <= 1'b1;
        end else begin
            // Zero wait states: ready stays high, but comes from a flop like every output
            pready_q <= 1'b1;
            prdata_q <= (psel_in && !penable_in && !pwrite_in) ? rd_mux : 32'h0;
            pslverr_q <= psel_in && !penable_in && !mapped;
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign run_out = run_q;
    assign ctrl_reset_out = ctrl_reset_q;
    assign arb_mode_out = arb_mode_q;
    assign page_shift_out = page_shift_q;
    assign command_set_out = cmdset_out_q;
    assign config_error_out = cfg_err_q;
endmodule : ccf_config_regs

/* shared/ccf_pkg.sv */
// Package for the controller configuration register bank
package ccf_pkg;
    // Register byte addresses (chosen map)
    localparam logic [11:0] CONFIG_ADDR = 12'h014;
    localparam logic [11:0] CAPS_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h01c;
    localparam logic [11:0] DERIVED_ADDR = 12'h020;
    // Configuration field positions
    localparam int RUN_POS = 0;
    localparam int RSVD_LO = 1;
    localparam int RSVD_HI = 3;
    localparam int CMDSET_LO = 4;
    localparam int CMDSET_HI = 6;
    localparam int PAGE_LO = 7;
    localparam int PAGE_HI = 10;
    localparam int ARB_LO = 11;
    localparam int ARB_HI = 13;
    // Reset values
    localparam logic [2:0] ARB_RESET = 3'h0;
    localparam logic [3:0] PAGE_RESET = 4'h0;
    localparam logic [2:0] CMDSET_RESET = 3'h0;
    localparam logic [4:0] PAGE_SHIFT_BASE = 5'h0c;
    // Arbitration and command set codes
    localparam logic [2:0] ARB_ROUND_ROBIN = 3'h0;
    localparam logic [2:0] ARB_WEIGHTED_URGENT = 3'h1;
    localparam logic [2:0] ARB_VENDOR = 3'h7;
    localparam logic [2:0] CMDSET_STORAGE = 3'h0;
    // Controller reset pulse length in cycles
    localparam int RESET_CYCLES = 4;
    typedef enum logic [2:0] {
        MODE_ROUND_ROBIN = 3'b001,
        MODE_WEIGHTED = 3'b010,
        MODE_OTHER = 3'b100
    } ccf_arb_mode_type;
endpackage : ccf_pkg

/* sim/ccf_config_asserts.sv */
// Concurrent checks on the configuration register bank ports
`timescale 1ns/1ps
module ccf_config_asserts (
    input wire logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in, prdata_out,
    input wire logic pready_out, pslverr_out, run_out, ctrl_reset_out, config_error_out,
    input wire logic [2:0] arb_mode_out, command_set_out,
    input wire logic [4:0] page_shift_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic acc = psel_in && penable_in && paddr_in == ccf_pkg::CONFIG_ADDR;
    wire logic [2:0] code = pwdata_in[13:11];
    wire logic [3:0] pg = pwdata_in[10:7];
    wire logic [2:0] cs = pwdata_in[6:4];
    wire logic [2:0] hot = code == 3'h0 ? 3'b001 : (code == 3'h1 ? 3'b010 : 3'b100);
    wire logic dflt = page_shift_out == 5'h0c && arb_mode_out == 3'b001 && command_set_out == 3'h0;
    sequence wr_open; acc && pwrite_in && !run_out; endsequence
    sequence wr_clear; acc && pwrite_in && run_out && !pwdata_in[0]; endsequence
    arb_decode_a: assert property (wr_open |=> ##1 arb_mode_out == $past(hot, 2))
        else $error("arbitration mode differs from written code");
    arb_reserved_a: assert property (wr_open ##0 (code > 3'h1 && code != 3'h7) |=> ##1 config_error_out)
        else $error("reserved arbitration code not flagged");
    page_size_a: assert property (wr_open |=> ##1 page_shift_out == 5'h0c + $past(pg, 2))
        else $error("page shift differs from written field");
    cmd_set_a: assert property (wr_open |=> ##1 command_set_out == $past(cs, 2))
        else $error("command set differs from written field");
    reset_pulse_a: assert property (wr_clear |=> ctrl_reset_out [*4] ##1 !ctrl_reset_out)
        else $error("controller reset pulse has wrong length");
    clear_dflt_a: assert property (wr_clear |=> ##1 dflt)
        else $error("fields not defaulted after run cleared");
    rsvd_read_a: assert property (acc && !pwrite_in |-> prdata_out[3:1] == 3'h0)
        else $error("reserved bits read nonzero");
    reset_val_a: assert property ($rose(rst_n_in) |-> dflt)
        else $error("fields not zero after reset");
endmodule : ccf_config_asserts
bind ccf_config_regs ccf_config_asserts chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .run_out(run_out), .ctrl_reset_out(ctrl_reset_out),
    .config_error_out(config_error_out), .arb_mode_out(arb_mode_out),
    .command_set_out(command_set_out), .page_shift_out(page_shift_out));

/* sim/tb_top.sv */
// Self-checking testbench for the configuration register bank
`timescale 1ns/1ps
module tb_top;
    logic clk_in = 0, rst_n_in = 0, psel = 0, penable = 0, pwrite = 0, serr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdata, prdata_out;
    logic pready_out, pslverr_out, run_out, ctrl_reset_out, config_error_out;
    logic [2:0] arb_mode_out, command_set_out;
    logic [4:0] page_shift_out;
    int err_count = 0, samples_checked = 0;
    ccf_config_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .run_out(run_out), .ctrl_reset_out(ctrl_reset_out), .arb_mode_out(arb_mode_out),
        .page_shift_out(page_shift_out), .command_set_out(command_set_out),
        .config_error_out(config_error_out));
    initial forever #5 clk_in = ~clk_in;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rdata = prdata_out;
        serr = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task settle;
        @(posedge clk_in);
        #1;
    endtask : settle
    task t_fields;
        for (int i = 0; i < 16; i++) begin
            // Reserved and upper bits written as ones must read back zero
            apb(1'b1, ccf_pkg::CONFIG_ADDR, {18'h3ffff, i[2:0], i[3:0], i[2:0], 4'he});
            settle();
            chk(32'(arb_mode_out), i[2:0] == 0 ? 1 : (i[2:0] == 1 ? 2 : 4));
            chk(32'(page_shift_out), 32'(5'h0c + i[3:0]));
            chk(32'(command_set_out), 32'(i[2:0]));
            chk(32'(config_error_out), 32'(i != 0));
            apb(1'b0, ccf_pkg::CONFIG_ADDR, 32'h0);
            chk(rdata, {18'h0, i[2:0], i[3:0], i[2:0], 4'h0});
        end
        $display("field test done");
    endtask : t_fields
    task t_run;
        apb(1'b1, ccf_pkg::CONFIG_ADDR, 32'h0000_0901);
        settle();
        chk(32'({run_out, arb_mode_out, page_shift_out}), 32'h1_4e);
        // A running controller must keep its fields
        apb(1'b1, ccf_pkg::CONFIG_ADDR, 32'h0000_02f1);
        settle();
        chk(32'(page_shift_out), 32'h0e);
        chk(32'(command_set_out), 32'h0);
        apb(1'b1, ccf_pkg::CONFIG_ADDR, 32'h0000_3ff0);
        for (int k = 0; k < 5; k++) begin
            #1;
            chk(32'(ctrl_reset_out), 32'(k < 4));
            @(posedge clk_in);
        end
        #1;
        chk(32'({run_out, arb_mode_out, page_shift_out, command_set_out}), 32'h160);
        $display("run test done");
    endtask : t_run
    task t_map;
        chk(32'({arb_mode_out, page_shift_out, command_set_out}), 32'h160);
        apb(1'b0, ccf_pkg::CAPS_ADDR, 32'h0);
        chk(rdata, 32'h0001_0300);
        apb(1'b0, 12'h100, 32'h0);
        chk(32'(serr), 32'h1);
        $display("map test done");
    endtask : t_map
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        settle();
        t_map();
        t_fields();
        t_run();
        conclude();
    end
    // Whole run needs about 140 cycles; this leaves ample margin
    initial begin
        #20000;
        err_count++;
        conclude();
    end
endmodule : tb_top
